//--- core/sbs_pkg.sv
// Summary of operation
// R1: Sample synchronous inputs on rising clock only.
// R2: Two-bit counter supplies low burst address.
// R3: Controller keeps sleep request low normally.
// R4: Sleep request high preserves contents, state.
// R5: Sleep release resumes with previous state.
// R6: Order select picks interleaved or linear.
// R7: Controller holds burst order level fixed; the bench changes it between bursts.
// R8: Output enable gates data drivers unclocked.
// R9: Registered inputs, registered pipelined read data.
// R10: Outputs stay driven one cycle past deselect.
// R11: Write pulse timed internally from registers.
// R12: Three chip selects, all must assert.
// R13: Per-lane write enables plus lane qualifier.
// R14: Global write writes regardless of lanes.
// R15: Narrow parts: 262144 words, 18 address bits.
// R16: Wide parts: 131072 words, parity on bus.
// R17: Burst step advances counter when low.
// R18: Either address strobe starts new access.
// R19: Common data bus, sampled in, tri-state out.
// R20: Linear adds modulo four, interleaved XORs.
// R21: Qualified lanes or global write update lanes.
package sbs_pkg;

   // ****************************************************************
   // Organisation of the two part families.
   // ****************************************************************
   localparam int NARROW_ADDR_BITS = 18;
   localparam int NARROW_WORDS     = 262144;
   localparam int NARROW_DATA_BITS = 18;
   localparam int NARROW_LANES     = 2;
   localparam int WIDE_ADDR_BITS   = 17;
   localparam int WIDE_WORDS       = 131072;
   localparam int WIDE_DATA_BITS   = 36;
   localparam int WIDE_LANES       = 4;

   // ****************************************************************
   // Burst counter, clock and reset values.
   // ****************************************************************
   localparam int         BEAT_BITS     = 2;
   localparam int         CLK_PERIOD_NS = 50;
   localparam logic [1:0] BEAT_RST      = 2'h0;
   localparam logic       FLAG_RST      = 1'h0;

   typedef enum logic [0:0]
   {
      SBS_RUN   = 1'b0,
      SBS_SLEEP = 1'b1
   } sbs_power_t;

   // Beat address from start value and beat count.
   function automatic logic [1:0] sbs_beat_addr(input logic [1:0] start,
                                                 input logic [1:0] count,
                                                 input logic       linear);
   begin
      if (linear)
         sbs_beat_addr = start + count; // R20
      else
         sbs_beat_addr = start ^ count; // R20
   end
   endfunction : sbs_beat_addr

endpackage : sbs_pkg

//--- core/sbs_burst_ctr.sv
`timescale 1ns/1ps
`default_nettype none
module sbs_burst_ctr
(
   input  wire logic       core_clk,
   input  wire logic       rst_sync_b,
   input  wire logic       load,
   input  wire logic       step,
   input  wire logic [1:0] start,
   input  wire logic       linear,
   output logic [1:0]      beat_lo
);

   logic [1:0] start_r;
   logic [1:0] start_nxt;
   logic [1:0] count_r;
   logic [1:0] count_nxt;

   // ****************************************************************
   // Two-bit burst counter.
   // ****************************************************************
   always_comb
   begin
      start_nxt = start_r;
      count_nxt = count_r;
      if (load)
      begin
         start_nxt = start;
         count_nxt = sbs_pkg::BEAT_RST;
      end
      else if (step)
         count_nxt = count_r + 2'h1; // R2 R17
   end

   always_ff @(posedge core_clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         start_r <= sbs_pkg::BEAT_RST;
         count_r <= sbs_pkg::BEAT_RST;
      end
      else
      begin
         start_r <= start_nxt;
         count_r <= count_nxt;
      end
   end

   // The order level is used without the clock.
   assign beat_lo = sbs_pkg::sbs_beat_addr(start_r, count_r, linear); // R6 R7 R20

endmodule : sbs_burst_ctr
`default_nettype wire

//--- core/sbs_sram_port.sv
`timescale 1ns/1ps
`default_nettype none
module sbs_sram_port
#(
   parameter int ADDR_BITS = sbs_pkg::NARROW_ADDR_BITS,
   parameter int DATA_BITS = sbs_pkg::NARROW_DATA_BITS,
   parameter int LANES     = sbs_pkg::NARROW_LANES
)
(
   input  wire logic                 core_clk,
   input  wire logic                 rst_b,
   input  wire logic [ADDR_BITS-1:0] addr_bus,
   input  wire logic [DATA_BITS-1:0] data_bus_in,
   output logic [DATA_BITS-1:0]      data_bus_out,
   output logic                      data_bus_oe,
   input  wire logic                 out_enable_n,
   input  wire logic                 chip_sel_low_a_n,
   input  wire logic                 chip_sel_high,
   input  wire logic                 chip_sel_low_b_n,
   input  wire logic [LANES-1:0]     lane_write_n,
   input  wire logic                 lane_write_qualify_n,
   input  wire logic                 all_lanes_write_n,
   input  wire logic                 cpu_addr_strobe_n,
   input  wire logic                 ctrl_addr_strobe_n,
   input  wire logic                 burst_step_n,
   input  wire logic                 burst_order_linear,
   input  wire logic                 sleep_request,
   output logic                      asleep
);

   localparam int LANE_BITS = DATA_BITS / LANES;
   localparam int WORDS     = 1 << ADDR_BITS;
   localparam int HI_BITS   = ADDR_BITS - sbs_pkg::BEAT_BITS;

   // ****************************************************************
   // Elaboration checks.
   // ****************************************************************
   if (ADDR_BITS < 3 || ADDR_BITS > 24)
      $error("ADDR_BITS out of range");
   if (LANES != sbs_pkg::NARROW_LANES && LANES != sbs_pkg::WIDE_LANES)
      $error("LANES must be 2 or 4");
   if (DATA_BITS % LANES != 0)
      $error("DATA_BITS must divide into lanes");

   // ****************************************************************
   // Reset release.
   // ****************************************************************
   logic rst_meta_r;
   logic rst_sync_b;

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_meta_r <= 1'b0;
         rst_sync_b <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_sync_b <= rst_meta_r;
      end
   end

   // ****************************************************************
   // Input register stage.
   // ****************************************************************
   sbs_pkg::sbs_power_t        power_r;
   sbs_pkg::sbs_power_t        power_nxt;
   logic [HI_BITS-1:0]         addr_hi_r;
   logic [HI_BITS-1:0]         addr_hi_nxt;
   logic [DATA_BITS-1:0]       din_r;
   logic [DATA_BITS-1:0]       din_nxt;
   logic [LANES-1:0]           lanes_r;
   logic [LANES-1:0]           lanes_nxt;
   logic                       active_r;
   logic                       active_nxt;
   logic                       acc_write_r;
   logic                       acc_write_nxt;
   logic                       selected;
   logic                       strobe;
   logic                       start;
   logic                       deselect;
   logic                       step;
   logic                       wr_req;
   logic [LANES-1:0]           wr_lanes;
   logic [1:0]                 beat_lo;

   always_comb
   begin
      selected = !chip_sel_low_a_n && chip_sel_high && !chip_sel_low_b_n; // R12
      strobe   = !cpu_addr_strobe_n || !ctrl_addr_strobe_n;                  // R18
      start    = strobe && selected;                                       // R18
      deselect = strobe && !selected;
      step     = !start && !deselect && active_r && !burst_step_n;         // R17
      if (!all_lanes_write_n)
         wr_lanes = {LANES{1'b1}};                                         // R14 R21
      else if (!lane_write_qualify_n)
         wr_lanes = ~lane_write_n;                                         // R13 R21
      else
         wr_lanes = {LANES{1'b0}};
      // A processor strobe always opens with a read.
      if (start && !cpu_addr_strobe_n)
         wr_lanes = {LANES{1'b0}};
      wr_req = |wr_lanes;

      power_nxt     = sleep_request ? sbs_pkg::SBS_SLEEP : sbs_pkg::SBS_RUN; // R4 R5
      addr_hi_nxt   = addr_hi_r;
      din_nxt       = din_r;
      lanes_nxt     = lanes_r;
      active_nxt    = active_r;
      acc_write_nxt = acc_write_r;
      // Nothing but power_r is captured while sleep_request is high, so all other state is kept.
      if (!sleep_request)                                                  // R4 R5 R3
      begin
         if (start)
            addr_hi_nxt = addr_bus[ADDR_BITS-1:sbs_pkg::BEAT_BITS];         // R1
         din_nxt       = data_bus_in;                                      // R1 R19
         lanes_nxt     = wr_lanes;                                         // R1
         active_nxt    = start || (active_r && !deselect);
         acc_write_nxt = wr_req && (start || (active_r && !deselect));
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         power_r     <= sbs_pkg::SBS_RUN;
         addr_hi_r   <= '0;
         din_r       <= '0;
         lanes_r     <= '0;
         active_r    <= sbs_pkg::FLAG_RST;
         acc_write_r <= sbs_pkg::FLAG_RST;
      end
      else
      begin
         power_r     <= power_nxt;
         addr_hi_r   <= addr_hi_nxt;
         din_r       <= din_nxt;
         lanes_r     <= lanes_nxt;
         active_r    <= active_nxt;
         acc_write_r <= acc_write_nxt;
      end
   end

   sbs_burst_ctr u_burst
   (
      .core_clk   (core_clk),
      .rst_sync_b (rst_sync_b),
      .load       (start && !sleep_request),                               // R2
      .step       (step && !sleep_request),                                // R17
      .start      (addr_bus[sbs_pkg::BEAT_BITS-1:0]),
      .linear     (burst_order_linear),                                    // R6
      .beat_lo    (beat_lo)
   );

   // ****************************************************************
   // Array and internally timed write.
   // ****************************************************************
   logic [DATA_BITS-1:0] mem_r [WORDS];
   logic [ADDR_BITS-1:0] acc_addr;
   logic                 mem_we;

   always_comb
   begin
      acc_addr = {addr_hi_r, beat_lo};
      mem_we   = active_r && acc_write_r && (power_r == sbs_pkg::SBS_RUN) && !sleep_request; // R11
   end

   // The array has no reset; contents survive sleep and reset alike.
   always_ff @(posedge core_clk)
   begin
      if (mem_we)
      begin
         for (int l = 0; l < LANES; l++)
         begin
            if (lanes_r[l])
               mem_r[acc_addr][l*LANE_BITS +: LANE_BITS] <= din_r[l*LANE_BITS +: LANE_BITS]; // R11 R21 R15 R16
         end
      end
   end

   // ****************************************************************
   // Output register stage and double-cycle deselect.
   // ****************************************************************
   logic [DATA_BITS-1:0] dout_r;
   logic [DATA_BITS-1:0] dout_nxt;
   logic                 out_valid_r;
   logic                 out_valid_nxt;
   logic                 tail_r;
   logic                 tail_nxt;
   logic                 rd_now;

   always_comb
   begin
      rd_now        = active_r && !acc_write_r;
      dout_nxt      = dout_r;
      out_valid_nxt = out_valid_r;
      tail_nxt      = tail_r;
      if (!sleep_request)
      begin
         if (rd_now)
            dout_nxt = mem_r[acc_addr];                                    // R9
         out_valid_nxt = rd_now;                                           // R9
         tail_nxt      = out_valid_r && !rd_now;                           // R10
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         dout_r      <= '0;
         out_valid_r <= sbs_pkg::FLAG_RST;
         tail_r      <= sbs_pkg::FLAG_RST;
      end
      else
      begin
         dout_r      <= dout_nxt;
         out_valid_r <= out_valid_nxt;
         tail_r      <= tail_nxt;
      end
   end

   assign data_bus_out = dout_r;                                           // R19
   // The output enable acts with no clock in the path.
   assign data_bus_oe  = (out_valid_r || tail_r) && !out_enable_n && !sleep_request; // R8 R10 R19
   assign asleep       = (power_r == sbs_pkg::SBS_SLEEP);                  // R4

endmodule : sbs_sram_port
`default_nettype wire

//--- bench/sbs_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module sbs_ctrl_model
#(parameter int DATA_BITS = 18)
(
   input wire logic                 core_clk,
   input wire logic                 drive_en,
   input wire logic [DATA_BITS-1:0] drive_data,
   input wire logic                 dev_oe,
   input wire logic [DATA_BITS-1:0] dev_data,
   output logic     [DATA_BITS-1:0] bus
);
   // ****************
   // Common data bus.
   // ****************
   logic [DATA_BITS-1:0] last_r = '0;
   always @(posedge core_clk)
      last_r <= bus;
   // A released bus toggles every cycle so a stale value never reads as valid.
   always_comb
      if (drive_en)
         bus = drive_data;
      else if (dev_oe)
         bus = dev_data;
      else
         bus = ~last_r;
endmodule : sbs_ctrl_model
`default_nettype wire

//--- bench/sbs_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sbs_port_chk
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic data_bus_oe,
   input wire logic out_enable_n,
   input wire logic chip_sel_low_a_n,
   input wire logic chip_sel_high,
   input wire logic chip_sel_low_b_n,
   input wire logic cpu_addr_strobe_n,
   input wire logic ctrl_addr_strobe_n,
   input wire logic sleep_request,
   input wire logic asleep
);
   // *************
   // Port timing.
   // *************
   logic sel, stb, rd, dsl, idl;
   assign sel = !chip_sel_low_a_n && chip_sel_high && !chip_sel_low_b_n;
   assign stb = !sleep_request && !(cpu_addr_strobe_n && ctrl_addr_strobe_n);
   assign rd  = stb && sel && !cpu_addr_strobe_n;
   assign dsl = stb && !sel;
   assign idl = !sleep_request && !out_enable_n && cpu_addr_strobe_n && ctrl_addr_strobe_n;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sleep_off_a: assert property (sleep_request |-> !data_bus_oe) else $error("oe in sleep");
   oe_gate_a: assert property (out_enable_n |-> !data_bus_oe) else $error("oe not gated");
   sleep_flag_a: assert property (sleep_request |=> asleep) else $error("no asleep");
   wake_flag_a: assert property (!sleep_request |=> !asleep) else $error("asleep stuck");
   wake_edge_a: assert property ($fell(sleep_request) |-> asleep ##1 !asleep) else $error("bad wake");
   read_pipe_a: assert property (rd ##2 idl |-> data_bus_oe) else $error("read not driven");
   tail_hold_a: assert property (rd ##1 dsl ##1 idl [*2] |-> data_bus_oe ##1 !data_bus_oe)
      else $error("bad tail");
   desel_off_a: assert property (dsl [*3] |=> !data_bus_oe) else $error("oe after deselect");
   cover property (rd ##1 dsl);
   cover property (dsl [*3]);
   cover property (sleep_request ##1 !sleep_request);
endmodule : sbs_port_chk
bind sbs_sram_port sbs_port_chk chk
   (.core_clk(core_clk), .rst_b(rst_b), .data_bus_oe(data_bus_oe), .out_enable_n(out_enable_n),
    .chip_sel_low_a_n(chip_sel_low_a_n), .chip_sel_high(chip_sel_high), .chip_sel_low_b_n(chip_sel_low_b_n),
    .cpu_addr_strobe_n(cpu_addr_strobe_n), .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
    .sleep_request(sleep_request), .asleep(asleep));
`default_nettype wire

//--- bench/sync_burst_sram_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sync_burst_sram_port_bench;
   // ****************************
   // Stimulus and result checks.
   // ****************************
   localparam int AB = 6;
   localparam int DB = 18;
   logic          core_clk = 1'h0, rst_b = 1'h0, oe, asl, oe_n = 1'h0, lin = 1'h0, slp = 1'h0;
   logic          cs_a_n = 1'h1, cs_h = 1'h0, cs_b_n = 1'h1, qual_n = 1'h1, gw_n = 1'h1, drv = 1'h0;
   logic          cpu_n = 1'h1, ctl_n = 1'h1, adv_n = 1'h1, rd_q = 1'h0, rd_d = 1'h0, rd_d2 = 1'h0;
   logic [1:0]    ln_n = 2'h3;
   logic [AB-1:0] addr = '0;
   logic [DB-1:0] wdat = '0, bus, dout, ref_m [64];
   logic [DB-1:0] exp_q [$];
   int            bad_count = 0, compares = 0;
   initial forever #25 core_clk = ~core_clk;
   sbs_sram_port #(.ADDR_BITS(AB), .DATA_BITS(DB), .LANES(2)) dut
   (.core_clk(core_clk), .rst_b(rst_b), .addr_bus(addr), .data_bus_in(bus), .data_bus_out(dout),
    .data_bus_oe(oe), .out_enable_n(oe_n), .chip_sel_low_a_n(cs_a_n), .chip_sel_high(cs_h),
    .chip_sel_low_b_n(cs_b_n), .lane_write_n(ln_n), .lane_write_qualify_n(qual_n),
    .all_lanes_write_n(gw_n), .cpu_addr_strobe_n(cpu_n), .ctrl_addr_strobe_n(ctl_n),
    .burst_step_n(adv_n), .burst_order_linear(lin), .sleep_request(slp), .asleep(asl));
   sbs_ctrl_model #(.DATA_BITS(DB)) ctl
   (.core_clk(core_clk), .drive_en(drv), .drive_data(wdat), .dev_oe(oe), .dev_data(dout), .bus(bus));
   task automatic stop_test();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test
   task automatic cmp_dat(input logic [DB-1:0] e);
      compares++;
      if (dout !== e || oe !== 1'h1)
      begin
         bad_count++;
         $display("[ERR] %0t data %h not %h", $time, dout, e);
      end
   endtask : cmp_dat
   task automatic cmp_bit(input logic g, input logic e);
      compares++;
      if (g !== e)
      begin
         bad_count++;
         $display("[ERR] %0t flag %b not %b", $time, g, e);
      end
   endtask : cmp_bit
   // Kinds: 0 idle, 1 read, 2 write, 3 lane write, 4 step, 5 unqualified lanes, 6 hold, 7 deselect, 8 lost write.
   task automatic op(input int k, input logic [AB-1:0] a, input logic [DB-1:0] d, input logic [1:0] l);
      @(posedge core_clk);
      {cs_a_n, cs_h, cs_b_n} <= k == 7 ? 3'h2 ^ (3'h1 << a[1:0]) : 3'h2;
      cpu_n  <= !(k inside {1, 7});
      ctl_n  <= !(k inside {2, 3, 5, 8});
      drv    <= k inside {2, 3, 5, 8};
      gw_n   <= !(k inside {2, 8});
      qual_n <= k != 3;
      adv_n  <= k != 4;
      ln_n   <= ~l;
      addr   <= a;
      wdat   <= d;
      rd_q   <= k inside {1, 4, 5, 6};
      if (k == 2)
         ref_m[a] = d;
      for (int i = 0; i < 2; i++)
         if (k == 3 && l[i])
            ref_m[a][i*9 +: 9] = d[i*9 +: 9];
      if (k inside {1, 4, 5, 6})
         exp_q.push_back(ref_m[a]);
   endtask : op
   task automatic burst(input logic [AB-1:0] a);
      logic [1:0] c;
      c = 2'h0;
      op(1, a, '0, 2'h0);
      for (int i = 1; i < 5; i++)
      begin
         if (i != 2)
            c++;
         op(i == 2 ? 6 : 4, {a[AB-1:2], lin ? a[1:0] + c : a[1:0] ^ c}, '0, 2'h0);
      end
   endtask : burst
   always @(posedge core_clk)
   begin
      rd_d  <= rd_q;
      rd_d2 <= rd_d;
   end
   always @(negedge core_clk)
      if (rd_d2)
         cmp_dat(exp_q.pop_front());
   initial
   begin
      repeat (2000) @(posedge core_clk);
      bad_count++;
      stop_test();
   end
   initial
   begin
      void'($urandom(32'h252d74a4));
      repeat (10) @(posedge core_clk);
      rst_b <= 1'h1;
      repeat (3) @(posedge core_clk);
      for (int a = 0; a < 64; a++)
         op(2, AB'(a), DB'($urandom), 2'h0);
      for (int i = 0; i < 6; i++)
         op(i < 3 ? 3 : 5, AB'(i), DB'($urandom), i < 3 ? 2'(i + 1) : 2'h3);
      for (int j = 0; j < 8; j++)
      begin
         repeat (2) op(0, '0, '0, 2'h0);
         lin <= j[0];
         burst(AB'($urandom));
      end
      op(1, AB'(5), '0, 2'h0);
      op(7, '0, '0, 2'h0);
      repeat (2) op(0, '0, '0, 2'h0);
      oe_n <= 1'h1;
      #1 cmp_bit(oe, 1'h0);
      oe_n <= 1'h0;
      #1 cmp_bit(oe, 1'h1);
      op(0, '0, '0, 2'h0);
      #1 cmp_bit(oe, 1'h0);
      for (int s = 0; s < 6; s++)
      begin
         op(s < 3 ? 7 : 0, AB'(s), '0, 2'h0);
         #1 cmp_bit(oe, 1'h0);
      end
      slp <= 1'h1;
      op(8, '0, DB'($urandom), 2'h0);
      op(0, '0, '0, 2'h0);
      #1 cmp_bit(asl, 1'h1);
      slp <= 1'h0;
      op(0, '0, '0, 2'h0);
      op(1, '0, '0, 2'h0);
      repeat (4) op(0, '0, '0, 2'h0);
      cmp_bit(exp_q.size() == 0, 1'h1);
      stop_test();
   end
endmodule : sync_burst_sram_port_bench
`default_nettype wire
